// File: hdl/aos_consts.svh
// alarm, status and discrete io block: register numbers, field positions,
// reset values and timing counts.
// assumes a 100 MHz core clock and 16-bit register words on the host port.
`ifndef AOS_CONSTS_SVH
`define AOS_CONSTS_SVH

// ----------------------------------------------------------------------
// register numbers (32-bit values span two words, high word first)
// ----------------------------------------------------------------------
`define AOS_REG_FAULT_STATUS    16'h9cc1
`define AOS_REG_WARNING_STATUS  16'h9cc3
`define AOS_REG_ALM1_FAULT_MASK 16'h9d08
`define AOS_REG_ALM1_WARN_MASK  16'h9d0a
`define AOS_REG_ALM2_FAULT_MASK 16'h9d0c
`define AOS_REG_ALM2_WARN_MASK  16'h9d0e
`define AOS_REG_PIN_POLARITY    16'h9d10

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define AOS_EMERGENCY_STOP_INPUT_FAULT_BIT     0
`define AOS_POL_ALM1_BIT        0
`define AOS_POL_ALM2_BIT        1
`define AOS_MASK_RESET          32'h0000_0000
`define AOS_POL_RESET           16'h0000
`define AOS_WORD_ZERO           16'h0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define AOS_CLK_KHZ             100000
`define AOS_BIAS_HOLD_MS        2500
`define AOS_SLOW_BLINK_MS       500
`define AOS_FAST_BLINK_MS       100
`define AOS_BIAS_HOLD_CYCLES    (`AOS_BIAS_HOLD_MS * `AOS_CLK_KHZ)
`define AOS_SLOW_BLINK_CYCLES   (`AOS_SLOW_BLINK_MS * `AOS_CLK_KHZ)
`define AOS_FAST_BLINK_CYCLES   (`AOS_FAST_BLINK_MS * `AOS_CLK_KHZ)

`endif

// File: hdl/aos_pkg.sv
// types shared by the alarm, status and discrete io block.
// assumes nothing beyond a SystemVerilog compiler.
package aos_pkg;

  // ----------------------------------------------------------------------
  // bias supply sequencing
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    AOS_BIAS_OFF  = 2'b00,
    AOS_BIAS_RUN  = 2'b01,
    AOS_BIAS_HOLD = 2'b10
  } aos_bias_state_t;

  typedef logic [15:0] aos_word_t;
  typedef logic [31:0] aos_dword_t;

endpackage : aos_pkg

// File: hdl/aos_alarm_channel.sv
// one isolated alarm output: masked fault and warning words, polarity.
// assumes status and mask words are synchronous to clk_i.
`timescale 1ns/1ps

module aos_alarm_channel #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] fault_word_i,
  input  wire logic [W-1:0] warning_word_i,
  input  wire logic [W-1:0] fault_mask_i,
  input  wire logic [W-1:0] warning_mask_i,
  input  wire logic         invert_i,
  output logic              alarm_o
);
  import aos_pkg::*;

  logic level_w;
  logic alarm_reg;

  // ----------------------------------------------------------------------
  // masking and polarity
  // ----------------------------------------------------------------------
  // any enabled fault or any enabled warning asserts the output
  assign level_w = (|(fault_word_i & fault_mask_i)) |
                   (|(warning_word_i & warning_mask_i)); // [RQ2] [RQ6] [RQ7] [RQ8]

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_reg <= 1'b0;
    end else if (ce_i) begin
      alarm_reg <= level_w ^ invert_i; // [RQ9] [RQ16]
    end
  end

  assign alarm_o = alarm_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_alarm_follows;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i |=> alarm_o == ($past(level_w) ^ $past(invert_i));
  endproperty
  a_alarm_follows: assert property (p_alarm_follows) // [RQ16]
    else $error("alarm output does not follow masked status and polarity");

  property p_masked_off;
    @(posedge clk_i) disable iff (!resetn_i)
      (ce_i && fault_mask_i == '0 && warning_mask_i == '0) |=> alarm_o == $past(invert_i);
  endproperty
  a_masked_off: assert property (p_masked_off) // [RQ6]
    else $error("alarm asserted while every mask bit is clear");

  property p_any_fault_all_ones;
    @(posedge clk_i) disable iff (!resetn_i)
      (ce_i && &fault_mask_i && |fault_word_i) |=> alarm_o != $past(invert_i);
  endproperty
  a_any_fault_all_ones: assert property (p_any_fault_all_ones) // [RQ8]
    else $error("all-ones fault mask failed to pass an active fault");

  c_alarm_active: cover property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i ##1 alarm_o != invert_i);

endmodule : aos_alarm_channel

// File: hdl/aos_status_io.sv
// alarm outputs, discrete inputs and front panel indicators of the supply.
// assumes a word-wide host register port (one request per cycle at most),
// inputs synchronous to clk_i, and a 100 MHz clock.
//
// What this block does
// RQ1 - two discrete alarm outputs from fault/warning events
// RQ2 - each alarm has fault and warning masks
// RQ3 - alarm one fault mask gates fault word
// RQ4 - alarm one warning mask gates warning word
// RQ5 - alarm two masks gate same status words
// RQ6 - mask one enables event, zero blocks it
// RQ7 - enabled events are ORed onto the output
// RQ8 - 32-bit masks, all ones passes everything
// RQ9 - output pin polarity selectable by register
// RQ10 - emergency stop fault while input not asserted
// RQ11 - controller keeps emergency stop asserted to run
// RQ12 - bias runs while enabled, holds 2.5 s
// RQ13 - normal mode indicators lit solid by state
// RQ14 - bootloader mode indicators blink or show host
// RQ15 - spare discrete input has no effect
// RQ16 - alarm is masked OR, then polarity, tracked
// RQ17 - masks clear to zero at reset
`timescale 1ns/1ps
`include "aos_consts.svh"

module aos_status_io #(
  parameter int unsigned BIAS_HOLD_CYCLES  = `AOS_BIAS_HOLD_CYCLES,
  parameter int unsigned SLOW_BLINK_CYCLES = `AOS_SLOW_BLINK_CYCLES,
  parameter int unsigned FAST_BLINK_CYCLES = `AOS_FAST_BLINK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  // host register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire aos_pkg::aos_word_t reg_wdata_i,
  output aos_pkg::aos_word_t      reg_rdata_o,
  output logic            reg_ack_o,
  output logic            reg_err_o,
  // status words from the conversion controller
  input  wire aos_pkg::aos_dword_t fault_status_i,
  input  wire aos_pkg::aos_dword_t warning_status_i,
  // discrete inputs
  input  wire logic       emergency_stop_input_i,
  input  wire logic       bias_enable_i,
  input  wire logic       ac_valid_i,
  input  wire logic       spare_input_i,
  // operating state
  input  wire logic       boot_mode_i,
  input  wire logic       standby_i,
  input  wire logic       running_i,
  input  wire logic       faulted_i,
  input  wire logic       host_connected_i,
  input  wire logic       host_xfer_i,
  input  wire logic       boot_error_i,
  // outputs
  output logic            alarm_output_one_o,
  output logic            alarm_output_two_o,
  output logic            bias_run_o,
  output logic            led_power_o,
  output logic            led_standby_o,
  output logic            led_operating_o,
  output logic            led_fault_o
);
  import aos_pkg::*;

  localparam int HCW = $clog2(BIAS_HOLD_CYCLES + 1);
  localparam int SCW = $clog2(SLOW_BLINK_CYCLES + 1);
  localparam int FCW = $clog2(FAST_BLINK_CYCLES + 1);

  aos_dword_t      fault_word_w;
  aos_dword_t      alm1_fault_mask_reg;
  aos_dword_t      alm1_warn_mask_reg;
  aos_dword_t      alm2_fault_mask_reg;
  aos_dword_t      alm2_warn_mask_reg;
  aos_word_t       polarity_reg;
  aos_word_t       rdata_next;
  logic            hit_next;
  logic            writable_next;
  aos_word_t       rdata_reg;
  logic            ack_reg;
  logic            err_reg;
  aos_bias_state_t bias_state_reg;
  logic [HCW-1:0]  hold_cnt_reg;
  logic            bias_run_reg;
  logic [SCW-1:0]  slow_cnt_reg;
  logic [FCW-1:0]  fast_cnt_reg;
  logic            slow_blink_reg;
  logic            fast_blink_reg;
  logic            led_power_reg;
  logic            led_standby_reg;
  logic            led_operating_reg;
  logic            led_fault_reg;
  logic            wr_w;
  logic            rd_w;

  // ----------------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------------
  // the stop input is asserted to allow power; its absence is a fault
  always_comb begin
    fault_word_w = fault_status_i;
    fault_word_w[`AOS_EMERGENCY_STOP_INPUT_FAULT_BIT] = fault_status_i[`AOS_EMERGENCY_STOP_INPUT_FAULT_BIT] |
                                         ~emergency_stop_input_i; // [RQ10] [RQ11]
  end

  // spare_input_i is deliberately left unread: it has no function yet [RQ15]

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  // a write wins over a read presented in the same cycle
  assign wr_w = ce_i & reg_wr_i;
  assign rd_w = ce_i & reg_rd_i & ~reg_wr_i;

  always_comb begin
    rdata_next    = `AOS_WORD_ZERO;
    hit_next      = 1'b1;
    writable_next = 1'b1;
    unique case (reg_addr_i)
      `AOS_REG_FAULT_STATUS: begin
        rdata_next    = fault_word_w[31:16];
        writable_next = 1'b0;
      end
      `AOS_REG_FAULT_STATUS + 16'h0001: begin
        rdata_next    = fault_word_w[15:0];
        writable_next = 1'b0;
      end
      `AOS_REG_WARNING_STATUS: begin
        rdata_next    = warning_status_i[31:16];
        writable_next = 1'b0;
      end
      `AOS_REG_WARNING_STATUS + 16'h0001: begin
        rdata_next    = warning_status_i[15:0];
        writable_next = 1'b0;
      end
      `AOS_REG_ALM1_FAULT_MASK:           rdata_next = alm1_fault_mask_reg[31:16];
      `AOS_REG_ALM1_FAULT_MASK + 16'h0001: rdata_next = alm1_fault_mask_reg[15:0];
      `AOS_REG_ALM1_WARN_MASK:            rdata_next = alm1_warn_mask_reg[31:16];
      `AOS_REG_ALM1_WARN_MASK + 16'h0001:  rdata_next = alm1_warn_mask_reg[15:0];
      `AOS_REG_ALM2_FAULT_MASK:           rdata_next = alm2_fault_mask_reg[31:16];
      `AOS_REG_ALM2_FAULT_MASK + 16'h0001: rdata_next = alm2_fault_mask_reg[15:0];
      `AOS_REG_ALM2_WARN_MASK:            rdata_next = alm2_warn_mask_reg[31:16];
      `AOS_REG_ALM2_WARN_MASK + 16'h0001:  rdata_next = alm2_warn_mask_reg[15:0];
      `AOS_REG_PIN_POLARITY:              rdata_next = polarity_reg;
      default: begin
        hit_next      = 1'b0;
        writable_next = 1'b0;
      end
    endcase
  end

  // mask writes land one word at a time; the alarm sees a half-updated
  // mask from the first word write until the second word write lands
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alm1_fault_mask_reg <= `AOS_MASK_RESET; // [RQ17]
      alm1_warn_mask_reg  <= `AOS_MASK_RESET; // [RQ17]
      alm2_fault_mask_reg <= `AOS_MASK_RESET; // [RQ17]
      alm2_warn_mask_reg  <= `AOS_MASK_RESET; // [RQ17]
      polarity_reg        <= `AOS_POL_RESET;
    end else if (wr_w) begin
      unique case (reg_addr_i)
        `AOS_REG_ALM1_FAULT_MASK:           alm1_fault_mask_reg[31:16] <= reg_wdata_i; // [RQ3]
        `AOS_REG_ALM1_FAULT_MASK + 16'h0001: alm1_fault_mask_reg[15:0]  <= reg_wdata_i; // [RQ3]
        `AOS_REG_ALM1_WARN_MASK:            alm1_warn_mask_reg[31:16]  <= reg_wdata_i; // [RQ4]
        `AOS_REG_ALM1_WARN_MASK + 16'h0001:  alm1_warn_mask_reg[15:0]   <= reg_wdata_i; // [RQ4]
        `AOS_REG_ALM2_FAULT_MASK:           alm2_fault_mask_reg[31:16] <= reg_wdata_i; // [RQ5]
        `AOS_REG_ALM2_FAULT_MASK + 16'h0001: alm2_fault_mask_reg[15:0]  <= reg_wdata_i; // [RQ5]
        `AOS_REG_ALM2_WARN_MASK:            alm2_warn_mask_reg[31:16]  <= reg_wdata_i; // [RQ5]
        `AOS_REG_ALM2_WARN_MASK + 16'h0001:  alm2_warn_mask_reg[15:0]   <= reg_wdata_i; // [RQ5]
        `AOS_REG_PIN_POLARITY:              polarity_reg               <= reg_wdata_i; // [RQ9]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= `AOS_WORD_ZERO;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else if (ce_i) begin
      ack_reg   <= wr_w | rd_w;
      err_reg   <= (rd_w & ~hit_next) | (wr_w & ~writable_next);
      rdata_reg <= (rd_w & hit_next) ? rdata_next : `AOS_WORD_ZERO;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_ack_o   = ack_reg;
  assign reg_err_o   = err_reg;

  // ----------------------------------------------------------------------
  // alarm outputs
  // ----------------------------------------------------------------------
  aos_alarm_channel #(
    .W (32)
  ) u_alarm_one (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .ce_i           (ce_i),
    .fault_word_i   (fault_word_w),
    .warning_word_i (warning_status_i),
    .fault_mask_i   (alm1_fault_mask_reg),
    .warning_mask_i (alm1_warn_mask_reg),
    .invert_i       (polarity_reg[`AOS_POL_ALM1_BIT]),
    .alarm_o        (alarm_output_one_o)
  ); // [RQ1] [RQ3] [RQ4]

  aos_alarm_channel #(
    .W (32)
  ) u_alarm_two (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .ce_i           (ce_i),
    .fault_word_i   (fault_word_w),
    .warning_word_i (warning_status_i),
    .fault_mask_i   (alm2_fault_mask_reg),
    .warning_mask_i (alm2_warn_mask_reg),
    .invert_i       (polarity_reg[`AOS_POL_ALM2_BIT]),
    .alarm_o        (alarm_output_two_o)
  ); // [RQ1] [RQ5]

  // ----------------------------------------------------------------------
  // bias supply
  // ----------------------------------------------------------------------
  // the supply draws from the ac line, so loss of ac ends it at once
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bias_state_reg <= AOS_BIAS_OFF;
      hold_cnt_reg   <= '0;
      bias_run_reg   <= 1'b0;
    end else if (ce_i) begin
      unique case (bias_state_reg)
        AOS_BIAS_OFF: begin
          if (bias_enable_i && ac_valid_i) begin
            bias_state_reg <= AOS_BIAS_RUN; // [RQ12]
            bias_run_reg   <= 1'b1;
          end
        end
        AOS_BIAS_RUN: begin
          if (!ac_valid_i) begin
            bias_state_reg <= AOS_BIAS_OFF;
            bias_run_reg   <= 1'b0;
          end else if (!bias_enable_i) begin
            bias_state_reg <= AOS_BIAS_HOLD; // [RQ12]
            hold_cnt_reg   <= HCW'(BIAS_HOLD_CYCLES - 1);
          end
        end
        AOS_BIAS_HOLD: begin
          if (!ac_valid_i || hold_cnt_reg == '0) begin
            bias_state_reg <= AOS_BIAS_OFF; // [RQ12]
            bias_run_reg   <= 1'b0;
          end else if (bias_enable_i) begin
            bias_state_reg <= AOS_BIAS_RUN;
          end else begin
            hold_cnt_reg <= hold_cnt_reg - 1'b1;
          end
        end
        default: begin
          bias_state_reg <= AOS_BIAS_OFF;
          bias_run_reg   <= 1'b0;
        end
      endcase
    end
  end

  assign bias_run_o = bias_run_reg;

  // ----------------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slow_cnt_reg   <= '0;
      fast_cnt_reg   <= '0;
      slow_blink_reg <= 1'b0;
      fast_blink_reg <= 1'b0;
    end else if (ce_i) begin
      if (slow_cnt_reg == SCW'(SLOW_BLINK_CYCLES - 1)) begin
        slow_cnt_reg   <= '0;
        slow_blink_reg <= ~slow_blink_reg;
      end else begin
        slow_cnt_reg <= slow_cnt_reg + 1'b1;
      end
      if (fast_cnt_reg == FCW'(FAST_BLINK_CYCLES - 1)) begin
        fast_cnt_reg   <= '0;
        fast_blink_reg <= ~fast_blink_reg;
      end else begin
        fast_cnt_reg <= fast_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      led_power_reg     <= 1'b0;
      led_standby_reg   <= 1'b0;
      led_operating_reg <= 1'b0;
      led_fault_reg     <= 1'b0;
    end else if (ce_i) begin
      if (boot_mode_i) begin
        led_power_reg     <= slow_blink_reg; // [RQ14]
        led_standby_reg   <= host_connected_i; // [RQ14]
        led_operating_reg <= host_xfer_i & fast_blink_reg; // [RQ14]
        led_fault_reg     <= boot_error_i; // [RQ14]
      end else begin
        led_power_reg     <= bias_run_reg; // [RQ13]
        led_standby_reg   <= standby_i; // [RQ13]
        led_operating_reg <= running_i; // [RQ13]
        led_fault_reg     <= faulted_i; // [RQ13]
      end
    end
  end

  assign led_power_o     = led_power_reg;
  assign led_standby_o   = led_standby_reg;
  assign led_operating_o = led_operating_reg;
  assign led_fault_o     = led_fault_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_emergency_stop_input_fault;
    !emergency_stop_input_i |-> fault_word_w[`AOS_EMERGENCY_STOP_INPUT_FAULT_BIT];
  endproperty
  a_emergency_stop_input_fault: assert property (p_emergency_stop_input_fault) // [RQ10]
    else $error("stop input released without a fault being reported");

  property p_mask_write;
    (wr_w && reg_addr_i == `AOS_REG_ALM1_FAULT_MASK)
      |=> alm1_fault_mask_reg[31:16] == $past(reg_wdata_i);
  endproperty
  a_mask_write: assert property (p_mask_write) // [RQ3]
    else $error("alarm one fault mask high word not written");

  property p_mask_readback;
    (rd_w && reg_addr_i == `AOS_REG_ALM2_WARN_MASK + 16'h0001)
      |=> reg_ack_o && reg_rdata_o == alm2_warn_mask_reg[15:0];
  endproperty
  a_mask_readback: assert property (p_mask_readback) // [RQ5]
    else $error("alarm two warning mask low word read back wrong");

  property p_bias_start;
    (ce_i && bias_state_reg == AOS_BIAS_OFF && bias_enable_i && ac_valid_i)
      |=> bias_run_o;
  endproperty
  a_bias_start: assert property (p_bias_start) // [RQ12]
    else $error("bias did not start with enable and ac present");

  property p_bias_hold;
    (ce_i && bias_state_reg == AOS_BIAS_RUN && !bias_enable_i && ac_valid_i)
      |=> bias_run_o && bias_state_reg == AOS_BIAS_HOLD;
  endproperty
  a_bias_hold: assert property (p_bias_hold) // [RQ12]
    else $error("bias dropped at once instead of holding");

  property p_bias_end;
    (ce_i && bias_state_reg == AOS_BIAS_HOLD && hold_cnt_reg == '0) |=> !bias_run_o;
  endproperty
  a_bias_end: assert property (p_bias_end) // [RQ12]
    else $error("bias still on after hold time expired");

  property p_led_normal;
    (ce_i && !boot_mode_i)
      |=> led_power_o == $past(bias_run_reg) && led_fault_o == $past(faulted_i);
  endproperty
  a_led_normal: assert property (p_led_normal) // [RQ13]
    else $error("normal mode indicators do not follow state");

  property p_led_boot;
    (ce_i && boot_mode_i)
      |=> led_standby_o == $past(host_connected_i) && led_fault_o == $past(boot_error_i);
  endproperty
  a_led_boot: assert property (p_led_boot) // [RQ14]
    else $error("bootloader indicators do not follow host state");

  property p_masks_clear;
    $rose(resetn_i) |-> alm1_fault_mask_reg == '0 && alm2_warn_mask_reg == '0;
  endproperty
  a_masks_clear: assert property (p_masks_clear) // [RQ17]
    else $error("masks not cleared by reset");

  c_bias_hold: cover property (bias_state_reg == AOS_BIAS_HOLD ##1 bias_state_reg == AOS_BIAS_RUN);
  c_boot_xfer: cover property (boot_mode_i && host_xfer_i && led_operating_o);
  c_reg_err:   cover property (reg_err_o);

endmodule : aos_status_io

// File: tb/aos_field_model.sv
// field wiring model: discrete inputs seen by the status and io block.
// assumes the bench raises a request line to change a level.
`timescale 1ns/1ps

module aos_field_model (
  input  wire logic stop_req_i,
  input  wire logic bias_req_i,
  input  wire logic ac_req_i,
  input  wire logic spare_req_i,
  output logic      emergency_stop_input_o,
  output logic      bias_en_o,
  output logic      ac_ok_o,
  output logic      spare_o
);
  // ----------------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------------
  // the loop stays closed unless a test opens it on purpose
  assign emergency_stop_input_o   = ~stop_req_i;
  assign bias_en_o = bias_req_i;
  assign ac_ok_o   = ac_req_i;
  assign spare_o   = spare_req_i;
endmodule : aos_field_model

// File: tb/aos_status_io_tb_top.sv
// self-checking bench for the alarm, status and discrete io block.
// assumes the design and aos_consts.svh are compiled first.
`timescale 1ns/1ps
`include "aos_consts.svh"

module aos_status_io_tb_top;
  import aos_pkg::*;
  localparam int unsigned HOLD = 8;
  localparam int unsigned SLOW = 4;
  logic       clk_i, resetn_i, wr, rd, ack, err, a1, a2, brun;
  logic       stop, bias, ac, spare, es, be, av, sp, p;
  logic       bm, sb, rn, fl, hc, hx, be_err, lp, ls, lo, lf;
  logic [15:0] addr, a;
  aos_word_t  wd, rdat;
  aos_dword_t fs, ws, s;
  int         miscompares = 0;
  int         checks = 0;

  aos_field_model FM (.stop_req_i(stop), .bias_req_i(bias), .ac_req_i(ac),
    .spare_req_i(spare), .emergency_stop_input_o(es), .bias_en_o(be), .ac_ok_o(av), .spare_o(sp));

  aos_status_io #(.BIAS_HOLD_CYCLES(HOLD), .SLOW_BLINK_CYCLES(SLOW),
    .FAST_BLINK_CYCLES(2)) DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_ack_o(ack),
    .reg_err_o(err), .fault_status_i(fs), .warning_status_i(ws),
    .emergency_stop_input_i(es), .bias_enable_i(be), .ac_valid_i(av),
    .spare_input_i(sp), .boot_mode_i(bm), .standby_i(sb), .running_i(rn),
    .faulted_i(fl), .host_connected_i(hc), .host_xfer_i(hx), .boot_error_i(be_err),
    .alarm_output_one_o(a1), .alarm_output_two_o(a2), .bias_run_o(brun),
    .led_power_o(lp), .led_standby_o(ls), .led_operating_o(lo), .led_fault_o(lf));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // a request is taken at the next edge and its answer stands only until the
  // edge after, so the answer is looked at just after the taking edge
  task automatic wrw(input logic [15:0] ad, input aos_word_t d, input logic e);
    addr = ad; wd = d; wr = 1;
    step(1);
    chk(ack, 1); chk(err, e);
    wr = 0;
    step(1);
  endtask : wrw

  task automatic rdw(input logic [15:0] ad, input aos_word_t d, input logic e);
    addr = ad; rd = 1;
    step(1);
    chk(ack, 1); chk(err, e); chk(rdat, d);
    rd = 0;
    step(1);
  endtask : rdw

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    resetn_i = 0; wr = 0; rd = 0; addr = 0; wd = 0; fs = 0; ws = 0;
    {stop, bias, ac, spare, bm, sb, rn, fl, hc, hx, be_err} = '0;
    step(10);
    resetn_i = 1;
    rdw(`AOS_REG_ALM1_FAULT_MASK, 16'h0000, 0);
    fs = 32'hffff_ffff; ws = 32'hffff_ffff;
    step(2);
    chk(a1, 0); chk(a2, 0);
    $display("reset test done");
    // each mask in turn passes bits 31 and 0 only, for its own output
    for (int i = 0; i < 4; i++) begin
      a = `AOS_REG_ALM1_FAULT_MASK + 16'(2 * i);
      wrw(a, 16'h8000, 0); wrw(a + 16'h0001, 16'h0001, 0);
      rdw(a + 16'h0001, 16'h0001, 0);
      for (int k = 0; k < 2; k++) begin
        s = k ? 32'h7fff_fffe : 32'h8000_0000;
        fs = i[0] ? '0 : s; ws = i[0] ? s : '0;
        step(2);
        chk(a1, k == 0 && i < 2); chk(a2, k == 0 && i >= 2);
      end
      wrw(a, 16'h0000, 0); wrw(a + 16'h0001, 16'h0000, 0);
    end
    $display("mask test done");
    for (int i = 0; i < 8; i++) wrw(`AOS_REG_ALM1_FAULT_MASK + 16'(i), 16'hffff, 0);
    fs = 0; ws = 32'h0000_0100;
    step(2);
    chk({a1, a2}, 2'b11);
    wrw(`AOS_REG_PIN_POLARITY, 16'h0001, 0);
    step(1);
    chk({a1, a2}, 2'b01);
    rdw(`AOS_REG_PIN_POLARITY, 16'h0001, 0);
    wrw(`AOS_REG_PIN_POLARITY, 16'h0003, 0); ws = 0;
    step(2);
    chk({a1, a2}, 2'b11);
    wrw(`AOS_REG_PIN_POLARITY, 16'h0000, 0); stop = 1;
    step(2);
    chk({a1, a2}, 2'b11);
    stop = 0; spare = 1;
    step(2);
    chk({a1, a2}, 2'b00);
    $display("alarm test done");
    wrw(`AOS_REG_FAULT_STATUS, 16'hffff, 1);
    rdw(16'h0001, 16'h0000, 1);
    $display("refusal test done");
    sb = 1; fl = 1; rn = 1; bias = 1; ac = 1;
    step(3);
    chk({brun, lp, ls, lo, lf}, 5'b11111);
    bias = 0;
    step(HOLD);
    chk(brun, 1);
    step(2);
    chk(brun, 0);
    bm = 1; hc = 1; be_err = 1;
    step(2);
    chk({ls, lo, lf}, 3'b101);
    p = lp;
    step(SLOW);
    chk(lp, !p);
    hx = 1;
    step(1);
    p = lo;
    step(2);
    chk(lo, !p);
    $display("bias and indicator test done");
    test_done;
  end

  initial begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule : aos_status_io_tb_top
